// ==== src/fsp_pin_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fsp_consts.svh"
// Contract
// R1: Reset pin low refuses all operations
// R2: Wait pin floats until config bit set
// R3: Same config bit selects wait polarity
// R4: Wait flags burst data not yet valid
// R5: Write buffers on while strobe low
// R6: SRAM writes only under its write strobe
// R7: Upper lane only under upper select
// R8: Lower lane only under lower select
// R9: Host ties both lane selects together
// R10: Protect low enforces lock-down, refuses unlock
// R11: Protect high lets software unlock blocks
// R12: Supply at lockout blocks program and erase
// R13: Chip enable high floats data, wait
// R14: Output enable high floats all outputs
// R15: Flash clock serves burst mode only
// R16: Reset pin acts asynchronously on state
module fsp_pin_ctrl (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic flash_clk,
  input wire logic flash_rst_n,
  input wire fsp_pkg::fsp_flash_pins_t flash_pins,
  input wire fsp_pkg::fsp_sram_pins_t sram_pins,
  input wire logic [`FSP_DQ_W-1:0] dq_in,
  input wire logic [`FSP_ADDR_W-1:0] addr_in,
  input wire logic vpp_lockout,
  input wire logic cfg_load,
  input wire logic cfg_wait_bit,
  input wire logic cfg_burst_en,
  input wire logic [`FSP_DQ_W-1:0] flash_rd_data,
  input wire logic rd_data_ok,
  input wire logic unlock_req,
  input wire logic blk_locked_down,
  input wire logic pe_req,
  input wire logic [`FSP_DQ_W-1:0] sram_rd_data,
  output logic [`FSP_DQ_W-1:0] flash_dq_o,
  output logic flash_dq_oe,
  output logic wait_o,
  output logic wait_oe,
  output logic wbuf_en,
  output logic flash_wr_valid,
  output fsp_pkg::fsp_wr_t flash_wr,
  output logic lockdown_on,
  output logic unlock_grant,
  output logic unlock_reject,
  output logic pe_start,
  output logic pe_blocked,
  output logic sram_array_we,
  output logic [1:0] sram_lane_en,
  output logic [`FSP_ADDR_W-1:0] sram_addr,
  output logic [`FSP_DQ_W-1:0] sram_wr_data,
  output logic [`FSP_DQ_W-1:0] sram_dq_o,
  output logic [1:0] sram_dq_oe,
  output logic lane_split_err
);
  import fsp_pkg::*;

  // ==========================================
  // Reset: asserted at once, released on the clock
  logic arst;
  logic [1:0] sys_rel_reg;
  logic [1:0] link_rel_reg;
  logic core_rst;
  logic link_rst;

  // R16: asynchronous reset pin
  assign arst = rst | ~flash_rst_n;

  always_ff @(posedge sys_clk or posedge arst)
  begin
    if (arst)
      sys_rel_reg <= 2'h0;
    else
      sys_rel_reg <= {sys_rel_reg[0], 1'b1};
  end

  always_ff @(posedge flash_clk or posedge arst)
  begin
    if (arst)
      link_rel_reg <= 2'h0;
    else
      link_rel_reg <= {link_rel_reg[0], 1'b1};
  end

  // R1: hold everything while pin low
  assign core_rst = ~sys_rel_reg[1];
  assign link_rst = ~link_rel_reg[1];

  // ==========================================
  // Pin synchronisers
  localparam int PIN_W = $bits(fsp_flash_pins_t) + $bits(fsp_sram_pins_t) + `FSP_DQ_W + `FSP_ADDR_W + 1;
  fsp_flash_pins_t fp_s;
  fsp_sram_pins_t sp_s;
  logic [`FSP_DQ_W-1:0] dq_s;
  logic [`FSP_ADDR_W-1:0] addr_s;
  logic lockout_s;
  logic inval_s;

  fsp_sync #(.W(PIN_W), .STAGES(`FSP_SYNC_STAGES)) u_pin_sync (
    .clk(sys_clk),
    .rst(rst),
    .d({flash_pins, sram_pins, dq_in, addr_in, vpp_lockout}),
    .q({fp_s, sp_s, dq_s, addr_s, lockout_s})
  );

  // ==========================================
  // Configuration and ready flag
  logic wait_bit_reg;
  logic burst_en_reg;
  logic ready_reg;

  always_ff @(posedge sys_clk or posedge core_rst)
  begin
    if (core_rst)
    begin
      wait_bit_reg <= `FSP_WAIT_BIT_RST;
      burst_en_reg <= `FSP_BURST_EN_RST;
    end
    else if (clk_en && cfg_load)
    begin
      wait_bit_reg <= cfg_wait_bit;
      burst_en_reg <= cfg_burst_en;
    end
  end

  // Registered so the link side sees a clean level
  always_ff @(posedge sys_clk or posedge core_rst)
  begin
    if (core_rst)
      ready_reg <= 1'b0;
    else if (clk_en)
      ready_reg <= rd_data_ok;
  end

  // ==========================================
  // Link domain: burst tracking on the flash clock
  logic ce_l;
  logic adv_l;
  logic burst_l;
  logic ready_l;
  logic en_l;
  fsp_link_state_t link_state_reg;
  logic inval_reg;

  fsp_sync #(.W(5), .STAGES(`FSP_SYNC_STAGES)) u_link_sync (
    .clk(flash_clk),
    .rst(link_rst),
    .d({flash_pins.ce_n, flash_pins.adv_n, burst_en_reg, ready_reg, clk_en}),
    .q({ce_l, adv_l, burst_l, ready_l, en_l})
  );

  // R15: clock edges only matter in burst mode
  always_ff @(posedge flash_clk or posedge link_rst)
  begin
    if (link_rst)
      link_state_reg <= FSP_LINK_IDLE;
    else if (en_l)
    begin
      case (link_state_reg)
        FSP_LINK_IDLE:
          if (burst_l && !ce_l && !adv_l)
            link_state_reg <= FSP_LINK_BURST;
        FSP_LINK_BURST:
          if (ce_l || !burst_l)
            link_state_reg <= FSP_LINK_IDLE;
        default:
          link_state_reg <= FSP_LINK_IDLE;
      endcase
    end
  end

  // R4: flag data not yet valid
  always_ff @(posedge flash_clk or posedge link_rst)
  begin
    if (link_rst)
      inval_reg <= 1'b0;
    else if (en_l)
      inval_reg <= (link_state_reg == FSP_LINK_BURST) && !ready_l;
  end

  fsp_sync #(.W(1), .STAGES(`FSP_SYNC_STAGES)) u_wait_sync (
    .clk(sys_clk),
    .rst(core_rst),
    .d(inval_reg),
    .q(inval_s)
  );

  // ==========================================
  // Flash outputs
  logic flash_rd;

  // R13: R14: float on either enable high
  assign flash_rd = !fp_s.ce_n && !fp_s.oe_n && fp_s.we_n;

  always_ff @(posedge sys_clk or posedge core_rst)
  begin
    if (core_rst)
    begin
      flash_dq_oe <= 1'b0;
      flash_dq_o <= '0;
    end
    else if (clk_en)
    begin
      flash_dq_oe <= flash_rd;
      flash_dq_o <= flash_rd_data;
    end
  end

  // R2: R3: bit enables driver and sets level
  always_ff @(posedge sys_clk or posedge core_rst)
  begin
    if (core_rst)
    begin
      wait_oe <= 1'b0;
      wait_o <= 1'b0;
    end
    else if (clk_en)
    begin
      wait_oe <= wait_bit_reg && !fp_s.ce_n && !fp_s.oe_n;
      wait_o <= wait_bit_reg ? inval_s : !inval_s;
    end
  end

  // ==========================================
  // Flash write capture
  logic we_d_reg;

  always_ff @(posedge sys_clk or posedge core_rst)
  begin
    if (core_rst)
      we_d_reg <= 1'b1;
    else if (clk_en)
      we_d_reg <= fp_s.we_n;
  end

  // R5: buffers follow strobe, latch on rise
  always_ff @(posedge sys_clk or posedge core_rst)
  begin
    if (core_rst)
    begin
      wbuf_en <= 1'b0;
      flash_wr_valid <= 1'b0;
      flash_wr <= '0;
    end
    else if (clk_en)
    begin
      wbuf_en <= !fp_s.ce_n && !fp_s.we_n;
      flash_wr_valid <= !fp_s.ce_n && fp_s.we_n && !we_d_reg;
      if (!fp_s.ce_n && fp_s.we_n && !we_d_reg)
        flash_wr <= '{addr: addr_s, data: dq_s, locked_out: lockout_s};
    end
  end

  // ==========================================
  // Lock-down and program supply guard
  always_ff @(posedge sys_clk or posedge core_rst)
  begin
    if (core_rst)
    begin
      lockdown_on <= 1'b1;
      unlock_grant <= 1'b0;
      unlock_reject <= 1'b0;
    end
    else if (clk_en)
    begin
      lockdown_on <= !fp_s.wp_n;
      // R10: R11: protect pin gates unlock
      unlock_reject <= unlock_req && blk_locked_down && !fp_s.wp_n;
      unlock_grant <= unlock_req && !(blk_locked_down && !fp_s.wp_n);
    end
  end

  // R12: no array change at lockout
  always_ff @(posedge sys_clk or posedge core_rst)
  begin
    if (core_rst)
    begin
      pe_start <= 1'b0;
      pe_blocked <= 1'b0;
    end
    else if (clk_en)
    begin
      pe_start <= pe_req && !lockout_s;
      pe_blocked <= pe_req && lockout_s;
    end
  end

  // ==========================================
  // SRAM control
  logic sram_sel;
  logic sram_rd;

  assign sram_sel = !sp_s.cs1_n && sp_s.cs2;
  assign sram_rd = sram_sel && !sp_s.oe_n && sp_s.we_n;

  always_ff @(posedge sys_clk or posedge core_rst)
  begin
    if (core_rst)
    begin
      sram_array_we <= 1'b0;
      sram_lane_en <= 2'h0;
      sram_addr <= '0;
      sram_wr_data <= '0;
    end
    else if (clk_en)
    begin
      // R6: write only under strobe
      sram_array_we <= sram_sel && !sp_s.we_n;
      // R7: R8: per-lane enables
      sram_lane_en <= {sram_sel && !sp_s.ub_n, sram_sel && !sp_s.lb_n};
      sram_addr <= addr_s;
      sram_wr_data <= dq_s;
    end
  end

  always_ff @(posedge sys_clk or posedge core_rst)
  begin
    if (core_rst)
    begin
      sram_dq_oe <= 2'h0;
      sram_dq_o <= '0;
      lane_split_err <= 1'b0;
    end
    else if (clk_en)
    begin
      sram_dq_oe <= {sram_rd && !sp_s.ub_n, sram_rd && !sp_s.lb_n};
      sram_dq_o <= sram_rd_data;
      // R9: split selects are a host fault
      lane_split_err <= sram_sel && (sp_s.ub_n != sp_s.lb_n);
    end
  end

  // ==========================================
  // Checks
  property p_rst_quiet;
    @(posedge sys_clk) disable iff (rst)
    !flash_rst_n |=> !flash_wr_valid && !flash_dq_oe && !wait_oe && !pe_start;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("op during reset"); // R1

  property p_wait_float;
    @(posedge sys_clk) disable iff (core_rst)
    !wait_bit_reg |=> !wait_oe;
  endproperty
  a_wait_float: assert property (p_wait_float) else $error("wait driven while disabled"); // R2

  property p_wait_level;
    @(posedge sys_clk) disable iff (core_rst)
    clk_en && wait_bit_reg |=> wait_o == $past(inval_s);
  endproperty
  a_wait_level: assert property (p_wait_level) else $error("wait polarity wrong"); // R3

  property p_burst_valid;
    @(posedge flash_clk) disable iff (link_rst)
    en_l && link_state_reg == FSP_LINK_BURST && ready_l |=> !inval_reg;
  endproperty
  a_burst_valid: assert property (p_burst_valid) else $error("wait on valid data"); // R4

  property p_wr_latch;
    @(posedge sys_clk) disable iff (core_rst)
    clk_en && !fp_s.ce_n && fp_s.we_n && !we_d_reg |=> flash_wr_valid && flash_wr.data == $past(dq_s);
  endproperty
  a_wr_latch: assert property (p_wr_latch) else $error("write not latched"); // R5

  property p_sram_we;
    @(posedge sys_clk) disable iff (core_rst)
    clk_en && sp_s.we_n |=> !sram_array_we;
  endproperty
  a_sram_we: assert property (p_sram_we) else $error("sram write without strobe"); // R6

  property p_upper_lane;
    @(posedge sys_clk) disable iff (core_rst)
    clk_en && sp_s.ub_n |=> !sram_lane_en[1] && !sram_dq_oe[1];
  endproperty
  a_upper_lane: assert property (p_upper_lane) else $error("upper lane active"); // R7

  property p_lower_lane;
    @(posedge sys_clk) disable iff (core_rst)
    clk_en && sp_s.lb_n |=> !sram_lane_en[0] && !sram_dq_oe[0];
  endproperty
  a_lower_lane: assert property (p_lower_lane) else $error("lower lane active"); // R8

  property p_lockdown;
    @(posedge sys_clk) disable iff (core_rst)
    clk_en && unlock_req && blk_locked_down && !fp_s.wp_n |=> unlock_reject && !unlock_grant;
  endproperty
  a_lockdown: assert property (p_lockdown) else $error("locked block unlocked"); // R10

  property p_unlock_free;
    @(posedge sys_clk) disable iff (core_rst)
    clk_en && unlock_req && fp_s.wp_n |=> unlock_grant && !lockdown_on;
  endproperty
  a_unlock_free: assert property (p_unlock_free) else $error("unlock refused"); // R11

  property p_lockout;
    @(posedge sys_clk) disable iff (core_rst)
    clk_en && pe_req && lockout_s |=> !pe_start && pe_blocked;
  endproperty
  a_lockout: assert property (p_lockout) else $error("program at lockout"); // R12

  property p_standby;
    @(posedge sys_clk) disable iff (core_rst)
    clk_en && (fp_s.ce_n || fp_s.oe_n) |=> !flash_dq_oe && !wait_oe;
  endproperty
  a_standby: assert property (p_standby) else $error("output driven in standby"); // R13 R14

  property p_clk_burst;
    @(posedge flash_clk) disable iff (link_rst)
    en_l && !burst_l |=> link_state_reg == FSP_LINK_IDLE ##1 !inval_reg;
  endproperty
  a_clk_burst: assert property (p_clk_burst) else $error("clock used outside burst"); // R15
endmodule : fsp_pin_ctrl
`default_nettype wire

// ==== src/fsp_consts.svh ====
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH
// ==========================================
// Bus widths and lane positions
`define FSP_DQ_W 16
`define FSP_ADDR_W 23
`define FSP_UB_MSB 15
`define FSP_UB_LSB 8
`define FSP_LB_MSB 7
`define FSP_LB_LSB 0
// ==========================================
// Crossing depth and reset values
`define FSP_SYNC_STAGES 2
`define FSP_WAIT_BIT_RST 1'b0
`define FSP_BURST_EN_RST 1'b0
`endif

// ==== src/fsp_pkg.sv ====
`include "fsp_consts.svh"
package fsp_pkg;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic adv_n;
    logic wp_n;
  } fsp_flash_pins_t;

  typedef struct packed {
    logic cs1_n;
    logic cs2;
    logic oe_n;
    logic we_n;
    logic ub_n;
    logic lb_n;
  } fsp_sram_pins_t;

  typedef struct packed {
    logic [`FSP_ADDR_W-1:0] addr;
    logic [`FSP_DQ_W-1:0] data;
    logic locked_out;
  } fsp_wr_t;

  typedef enum logic {
    FSP_LINK_IDLE,
    FSP_LINK_BURST
  } fsp_link_state_t;
endpackage : fsp_pkg

// ==== src/fsp_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fsp_consts.svh"
// ==========================================
// Multi-bit level synchroniser, one chain per bit
module fsp_sync #(
  parameter int W = 1,
  parameter int STAGES = `FSP_SYNC_STAGES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] chain_reg [STAGES];

  genvar i;
  generate
    for (i = 0; i < STAGES; i++)
    begin : g_stage
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          chain_reg[i] <= '0;
        else if (i == 0)
          chain_reg[i] <= d;
        else
          chain_reg[i] <= chain_reg[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate

  assign q = chain_reg[STAGES-1];
endmodule : fsp_sync
`default_nettype wire

// ==== test/fsp_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fsp_consts.svh"
// ==========================================
// Host side of the pins, changed off the falling edge
module fsp_host_model (
  input wire logic sys_clk,
  output logic flash_clk,
  output var fsp_pkg::fsp_flash_pins_t flash_pins,
  output var fsp_pkg::fsp_sram_pins_t sram_pins,
  output logic [`FSP_DQ_W-1:0] dq_in,
  output logic [`FSP_ADDR_W-1:0] addr_in
);
  import fsp_pkg::*;
  initial
  begin
    flash_clk = 1'b0;
    flash_pins = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, adv_n: 1'b1, wp_n: 1'b0};
    sram_pins = '{cs1_n: 1'b1, cs2: 1'b0, oe_n: 1'b1, we_n: 1'b1, ub_n: 1'b1, lb_n: 1'b1};
    dq_in = 16'h0000;
    addr_in = 23'h000000;
  end
  task automatic flash_set(input logic ce_n, input logic oe_n, input logic we_n, input logic adv_n);
    @(negedge sys_clk);
    flash_pins.ce_n = ce_n;
    flash_pins.oe_n = oe_n;
    flash_pins.we_n = we_n;
    flash_pins.adv_n = adv_n;
  endtask : flash_set
  task automatic wp_set(input logic v);
    @(negedge sys_clk);
    flash_pins.wp_n = v;
  endtask : wp_set
  task automatic sram_set(input logic sel, input logic wr);
    @(negedge sys_clk);
    sram_pins = '{cs1_n: !sel, cs2: sel, oe_n: wr, we_n: !wr, ub_n: !sel, lb_n: !sel};
  endtask : sram_set
  task automatic put(input logic [`FSP_ADDR_W-1:0] a, input logic [`FSP_DQ_W-1:0] d);
    @(negedge sys_clk);
    addr_in = a;
    dq_in = d;
  endtask : put
  // Released bus shows no stale data
  task automatic release_dq;
    @(negedge sys_clk);
    dq_in = ~dq_in;
  endtask : release_dq
  // Link clock runs only while this task pulses it, burst mode on or off
  task automatic burst(input int n);
    #1.3;
    repeat (n)
    begin
      #3 flash_clk = 1'b1;
      #3 flash_clk = 1'b0;
    end
  endtask : burst
endmodule : fsp_host_model
`default_nettype wire

// ==== test/flash_sram_pin_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fsp_consts.svh"
module flash_sram_pin_control_tb;
  import fsp_pkg::*;
  logic sys_clk, rst, clk_en, flash_clk, flash_rst_n, vpp_lockout, cfg_load, cfg_wait_bit, cfg_burst_en;
  logic rd_data_ok, unlock_req, blk_locked_down, pe_req, flash_dq_oe, wait_o, wait_oe, wbuf_en, flash_wr_valid;
  logic lockdown_on, unlock_grant, unlock_reject, pe_start, pe_blocked, sram_array_we, lane_split_err, seen;
  fsp_flash_pins_t flash_pins;
  fsp_sram_pins_t sram_pins;
  fsp_wr_t flash_wr;
  logic [`FSP_DQ_W-1:0] dq_in, flash_dq_o, sram_wr_data, sram_dq_o;
  logic [`FSP_ADDR_W-1:0] addr_in, sram_addr;
  logic [1:0] sram_lane_en, sram_dq_oe;
  int num_errors, n_compared;
  fsp_host_model host (.sys_clk, .flash_clk, .flash_pins, .sram_pins, .dq_in, .addr_in);
  fsp_pin_ctrl DUT (.sys_clk, .rst, .clk_en, .flash_clk, .flash_rst_n, .flash_pins, .sram_pins, .dq_in,
    .addr_in, .vpp_lockout, .cfg_load, .cfg_wait_bit, .cfg_burst_en, .flash_rd_data(16'ha5c3), .rd_data_ok,
    .unlock_req, .blk_locked_down, .pe_req, .sram_rd_data(16'h3c5a), .flash_dq_o, .flash_dq_oe, .wait_o,
    .wait_oe, .wbuf_en, .flash_wr_valid, .flash_wr, .lockdown_on, .unlock_grant, .unlock_reject, .pe_start,
    .pe_blocked, .sram_array_we, .sram_lane_en, .sram_addr, .sram_wr_data, .sram_dq_o, .sram_dq_oe,
    .lane_split_err);
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic settle;
    repeat (5) @(negedge sys_clk);
  endtask : settle
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic t_reset;
    host.flash_set(1'b0, 1'b1, 1'b0, 1'b1);
    settle();
    chk("wbuf_en", wbuf_en, 1);
    @(negedge sys_clk);
    flash_rst_n = 1'b0;
    pe_req = 1'b1;
    #2;
    chk("wbuf_en in reset", wbuf_en, 0);
    @(negedge sys_clk);
    pe_req = 1'b0;
    chk("pe_start in reset", pe_start, 0);
    flash_rst_n = 1'b1;
    settle();
    chk("wbuf_en after reset", wbuf_en, 1);
    host.flash_set(1'b1, 1'b1, 1'b1, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_flash_write;
    for (int v = 0; v < 3; v++)
    begin
      vpp_lockout = v[0];
      seen = 1'b0;
      host.put(23'h5a_0f31 + 23'(v), 16'hc3a5 ^ 16'(v));
      host.flash_set(v[1], 1'b1, 1'b0, 1'b1);
      settle();
      host.flash_set(v[1], 1'b1, 1'b1, 1'b1);
      repeat (8)
      begin
        @(negedge sys_clk);
        if (flash_wr_valid === 1'b1 && !seen)
        begin
          seen = 1'b1;
          chk("wr data", flash_wr.data, 16'hc3a5 ^ 16'(v));
          chk("wr addr", flash_wr.addr, 23'h5a_0f31 + 23'(v));
          chk("locked_out", flash_wr.locked_out, v[0]);
        end
      end
      chk("write captured", seen, !v[1]);
      host.release_dq();
      host.flash_set(1'b1, 1'b1, 1'b1, 1'b1);
    end
    vpp_lockout = 1'b0;
    $display("test flash write done");
  endtask : t_flash_write
  task automatic t_sram;
    host.put(23'h12_3456, 16'hbe71);
    host.sram_set(1'b1, 1'b1);
    settle();
    chk("sram we", sram_array_we, 1);
    chk("lanes", sram_lane_en, 2'b11);
    chk("sram data", sram_wr_data, 16'hbe71);
    chk("sram addr", sram_addr, 23'h12_3456);
    chk("split", lane_split_err, 0);
    host.sram_set(1'b1, 1'b0);
    settle();
    chk("sram we off", sram_array_we, 0);
    chk("sram read lanes", sram_dq_oe, 2'b11);
    chk("sram read data", sram_dq_o, 16'h3c5a);
    host.sram_set(1'b0, 1'b0);
    settle();
    chk("lanes off", sram_lane_en, 2'b00);
    chk("read lanes off", sram_dq_oe, 2'b00);
    $display("test sram done");
  endtask : t_sram
  task automatic t_lock;
    for (int w = 0; w < 2; w++)
    begin
      host.wp_set(w[0]);
      settle();
      chk("lockdown_on", lockdown_on, !w[0]);
      for (int l = 0; l < 2; l++)
      begin
        @(negedge sys_clk);
        blk_locked_down = l[0];
        unlock_req = 1'b1;
        @(negedge sys_clk);
        unlock_req = 1'b0;
        chk("grant", unlock_grant, !(l[0] && !w[0]));
        chk("reject", unlock_reject, l[0] && !w[0]);
      end
    end
    $display("test lock done");
  endtask : t_lock
  task automatic t_vpp;
    for (int v = 0; v < 2; v++)
    begin
      vpp_lockout = v[0];
      settle();
      pe_req = 1'b1;
      @(negedge sys_clk);
      pe_req = 1'b0;
      chk("pe_start", pe_start, !v[0]);
      chk("pe_blocked", pe_blocked, v[0]);
    end
    vpp_lockout = 1'b0;
    $display("test supply done");
  endtask : t_vpp
  task automatic cfg(input logic b, input logic e);
    @(negedge sys_clk);
    cfg_load = 1'b1;
    cfg_wait_bit = b;
    cfg_burst_en = e;
    @(negedge sys_clk);
    cfg_load = 1'b0;
  endtask : cfg
  task automatic t_wait;
    cfg(1'b0, 1'b1);
    host.flash_set(1'b0, 1'b0, 1'b1, 1'b0);
    settle();
    chk("wait floats", wait_oe, 0);
    cfg(1'b1, 1'b1);
    settle();
    chk("wait driven", wait_oe, 1);
    chk("dq drive", flash_dq_oe, 1);
    chk("dq data", flash_dq_o, 16'ha5c3);
    for (int k = 0; k < 2; k++)
    begin
      rd_data_ok = k[0];
      host.burst(10);
      settle();
      chk("wait level", wait_o, !k[0]);
    end
    host.flash_set(1'b0, 1'b1, 1'b1, 1'b0);
    settle();
    chk("oe_n wait", wait_oe, 0);
    chk("oe_n dq", flash_dq_oe, 0);
    host.flash_set(1'b1, 1'b0, 1'b1, 1'b1);
    settle();
    chk("ce_n wait", wait_oe, 0);
    chk("ce_n dq", flash_dq_oe, 0);
    cfg(1'b1, 1'b0);
    rd_data_ok = 1'b0;
    host.flash_set(1'b0, 1'b0, 1'b1, 1'b0);
    host.burst(10);
    settle();
    chk("clock ignored", wait_o, 0);
    host.flash_set(1'b1, 1'b1, 1'b1, 1'b1);
    $display("test wait done");
  endtask : t_wait
  initial
  begin
    {rst, clk_en, flash_rst_n} = 3'b111;
    {vpp_lockout, cfg_load, cfg_wait_bit, cfg_burst_en, rd_data_ok, unlock_req, blk_locked_down, pe_req} = 8'h00;
    num_errors = 0;
    n_compared = 0;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    settle();
    chk("lockdown after reset", lockdown_on, 1);
    t_reset();
    t_flash_write();
    t_sram();
    t_lock();
    t_vpp();
    t_wait();
    finish_test();
  end
  initial
  begin
    #60000;
    num_errors++;
    finish_test();
  end
endmodule : flash_sram_pin_control_tb
`default_nettype wire
